// ---- edge_sync.sv ----
// Two-flop synchroniser with edge detection for one asynchronous input.
// Assumes the input changes no faster than a quarter of the clock rate.
`timescale 1ns/10ps
module edge_sync (
    input wire logic clock,
    input wire logic rstN,
    input wire logic asyncIn,
    output logic rise,
    output logic fall
);

    logic metaStage;
    logic stableStage;
    logic prevStage;

    // ------------------------------------------------------------
    // Resample, then compare two settled samples
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            metaStage <= 1'b0;
            stableStage <= 1'b0;
            prevStage <= 1'b0;
        end else begin
            metaStage <= asyncIn;
            stableStage <= metaStage;
            prevStage <= stableStage;
        end
    end

    // Only settled samples feed the detector
    assign rise = stableStage & ~prevStage;
    assign fall = ~stableStage & prevStage;

endmodule : edge_sync

// ---- interval_timer.sv ----
// 8-bit modulo interval timer with four byte-wide registers.
// Assumes a register master with one-cycle strobes, read data taken the
// cycle after the read strobe, and an external clock pin at most a quarter
// of the bus rate.
`timescale 1ns/10ps

module interval_timer #(
    parameter int COUNT_W = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input interval_timer_pkg::reg_req_t regReq,
    output logic [7:0] rdData,
    input wire logic extTimerClockIn,
    input wire logic fixedClockTick,
    output logic overflowIrq,
    output logic overflowPulse,
    output logic counterRunning
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    initial begin
        if (COUNT_W < 1 || COUNT_W > interval_timer_pkg::REG_DATA_W) begin
            $error("interval_timer: COUNT_W must be 1 to 8");
        end
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rstMeta;
    logic rstN;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic overflowFlag;
    logic overflowIrqEnable;
    logic counterHalt;
    logic [1:0] clockSourceSelect;
    logic [3:0] prescaleShift;
    logic [COUNT_W-1:0] countValue;
    logic [COUNT_W-1:0] wrapLimit;
    logic clearArmed;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic hitStatus;
    logic hitClock;
    logic hitCount;
    logic hitLimit;
    logic wrStatus;
    logic wrClock;
    logic wrLimit;
    logic rdStatus;

    assign hitStatus = regReq.addr == interval_timer_pkg::OFS_STATUS_CONTROL;
    assign hitClock = regReq.addr == interval_timer_pkg::OFS_CLOCK_CONFIG;
    assign hitCount = regReq.addr == interval_timer_pkg::OFS_COUNT_VALUE;
    assign hitLimit = regReq.addr == interval_timer_pkg::OFS_WRAP_LIMIT;
    assign wrStatus = regReq.wrStrobe & hitStatus;
    assign wrClock = regReq.wrStrobe & hitClock;
    assign wrLimit = regReq.wrStrobe & hitLimit;
    assign rdStatus = regReq.rdStrobe & hitStatus;

    // Write-only self-clearing action; never stored
    logic counterClear;
    assign counterClear = wrStatus & regReq.wrData[interval_timer_pkg::SC_CLEAR_BIT];

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            overflowIrqEnable <= interval_timer_pkg::RST_IRQ_EN;
            counterHalt <= interval_timer_pkg::RST_HALT;
        end else if (wrStatus) begin
            overflowIrqEnable <= regReq.wrData[interval_timer_pkg::SC_IRQ_EN_BIT];
            counterHalt <= regReq.wrData[interval_timer_pkg::SC_HALT_BIT];
        end
    end

    // Bits 7:6 of the clock register hold nothing
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            clockSourceSelect <= interval_timer_pkg::RST_CLOCK_SOURCE;
            prescaleShift <= interval_timer_pkg::RST_PRESCALE;
        end else if (wrClock) begin
            clockSourceSelect <= regReq.wrData[interval_timer_pkg::CLK_SRC_LSB +:
                interval_timer_pkg::CLK_SRC_W];
            // Shifts past the maximum saturate rather than wrap
            if (regReq.wrData[interval_timer_pkg::CLK_PRESCALE_LSB +:
                    interval_timer_pkg::CLK_PRESCALE_W] > interval_timer_pkg::PRESCALE_MAX) begin
                prescaleShift <= interval_timer_pkg::PRESCALE_MAX;
            end else begin
                prescaleShift <= regReq.wrData[interval_timer_pkg::CLK_PRESCALE_LSB +:
                    interval_timer_pkg::CLK_PRESCALE_W];
            end
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            wrapLimit <= interval_timer_pkg::RST_WRAP_LIMIT[COUNT_W-1:0];
        end else if (wrLimit) begin
            wrapLimit <= regReq.wrData[COUNT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------
    logic extRise;
    logic extFall;
    logic sourceTick;
    logic countTick;
    logic running;

    edge_sync extSync (
        .clock(clock),
        .rstN(rstN),
        .asyncIn(extTimerClockIn),
        .rise(extRise),
        .fall(extFall)
    );

    always_comb begin
        case (interval_timer_pkg::clock_source_t'(clockSourceSelect))
            interval_timer_pkg::SRC_BUS: sourceTick = 1'b1;
            interval_timer_pkg::SRC_FIXED: sourceTick = fixedClockTick;
            interval_timer_pkg::SRC_EXT_FALL: sourceTick = extFall;
            interval_timer_pkg::SRC_EXT_RISE: sourceTick = extRise;
            default: sourceTick = 1'b0;
        endcase
    end

    // Halt freezes the prescaler too, so resuming keeps the phase
    assign running = ~counterHalt;

    tick_prescaler #(
        .DIV_W(8)
    ) prescaler (
        .clock(clock),
        .rstN(rstN),
        .clear(counterClear),
        .run(running),
        .srcTick(sourceTick),
        .shift(prescaleShift),
        .tick(countTick)
    );

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] wrapPoint;
    logic wrapNow;

    // A limit of zero lets the counter run through its full range
    assign wrapPoint = (wrapLimit == '0) ? {COUNT_W{1'b1}} : wrapLimit;
    assign wrapNow = countTick & (countValue == wrapPoint);

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            countValue <= interval_timer_pkg::RST_COUNT[COUNT_W-1:0];
        end else if (counterClear) begin
            countValue <= '0;
        end else if (wrapNow) begin
            countValue <= '0;
        end else if (countTick) begin
            countValue <= countValue + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag and its two-step clear
    // ------------------------------------------------------------
    logic flagClearByAck;
    logic flagClear;

    // Only a read that saw the flag set arms the clear
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            clearArmed <= 1'b0;
        end else if (wrStatus || !overflowFlag) begin
            clearArmed <= 1'b0;
        end else if (rdStatus) begin
            clearArmed <= 1'b1;
        end
    end

    assign flagClearByAck = wrStatus & clearArmed
        & ~regReq.wrData[interval_timer_pkg::SC_FLAG_BIT];
    assign flagClear = flagClearByAck | counterClear | wrLimit;

    // A wrap in the clearing cycle keeps the flag set
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            overflowFlag <= interval_timer_pkg::RST_FLAG;
        end else if (wrapNow) begin
            overflowFlag <= 1'b1;
        end else if (flagClear) begin
            overflowFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Request is a level; it follows the flag with one cycle of delay
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            overflowIrq <= 1'b0;
        end else begin
            overflowIrq <= overflowIrqEnable & overflowFlag;
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            overflowPulse <= 1'b0;
            counterRunning <= 1'b0;
        end else begin
            overflowPulse <= wrapNow;
            counterRunning <= running;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] next_rdData;

    always_comb begin
        next_rdData = interval_timer_pkg::UNMAPPED_READ;
        if (hitStatus) begin
            next_rdData[interval_timer_pkg::SC_FLAG_BIT] = overflowFlag;
            next_rdData[interval_timer_pkg::SC_IRQ_EN_BIT] = overflowIrqEnable;
            next_rdData[interval_timer_pkg::SC_CLEAR_BIT] = 1'b0;
            next_rdData[interval_timer_pkg::SC_HALT_BIT] = counterHalt;
        end else if (hitClock) begin
            next_rdData[interval_timer_pkg::CLK_SRC_LSB +:
                interval_timer_pkg::CLK_SRC_W] = clockSourceSelect;
            next_rdData[interval_timer_pkg::CLK_PRESCALE_LSB +:
                interval_timer_pkg::CLK_PRESCALE_W] = prescaleShift;
        end else if (hitCount) begin
            next_rdData[COUNT_W-1:0] = countValue;
        end else if (hitLimit) begin
            next_rdData[COUNT_W-1:0] = wrapLimit;
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rdData <= interval_timer_pkg::RST_READ_DATA;
        end else if (regReq.rdStrobe) begin
            rdData <= next_rdData;
        end else begin
            rdData <= interval_timer_pkg::RST_READ_DATA;
        end
    end

endmodule : interval_timer

// ---- interval_timer_chk.sv ----
// Concurrent checks on the interval timer ports.
// Assumes one bus clock and the registered read path of the timer.
`timescale 1ns/10ps
module interval_timer_chk #(
    parameter int COUNT_W = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input interval_timer_pkg::reg_req_t regReq,
    input wire logic [7:0] rdData,
    input wire logic extTimerClockIn,
    input wire logic fixedClockTick,
    input wire logic overflowIrq,
    input wire logic overflowPulse,
    input wire logic counterRunning
);
    // ----
    // Request decode
    // ----
    logic rd0;
    logic rd1;
    logic wr0;
    logic wr3;
    assign rd0 = regReq.rdStrobe && regReq.addr == 4'h0;
    assign rd1 = regReq.rdStrobe && regReq.addr == 4'h1;
    assign wr0 = regReq.wrStrobe && regReq.addr == 4'h0;
    assign wr3 = regReq.wrStrobe && regReq.addr == 4'h3;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ----
    // Checks
    // ----
    chk_read_slot: assert property (rdData != 8'h00 |-> $past(regReq.rdStrobe))
        else $error("read data outside read slot");
    chk_clear_bit: assert property ($past(rd0) |-> rdData[5] == 1'b0 && rdData[3:0] == 4'h0)
        else $error("control write-only bits read nonzero");
    chk_clk_unused: assert property ($past(rd1) |-> rdData[7:6] == 2'h0)
        else $error("clock config unused bits read nonzero");
    chk_pulse_single: assert property (overflowPulse |=> !overflowPulse)
        else $error("overflow pulse longer than one cycle");
    chk_halt_quiet: assert property (!counterRunning && !$past(counterRunning)
        && !$past(counterRunning, 2) |-> !overflowPulse)
        else $error("wrap while halted");
    chk_halt_set: assert property (wr0 && regReq.wrData[4] |-> ##2 !counterRunning)
        else $error("halt write did not stop counter");
    chk_halt_free: assert property (wr0 && !regReq.wrData[4] |-> ##2 counterRunning)
        else $error("halt release did not start counter");
    chk_reset_halt: assert property ($rose(nrst) |-> !counterRunning [*4])
        else $error("counter running after reset");
    chk_reset_mask: assert property ($rose(nrst) |-> !overflowIrq [*4])
        else $error("interrupt after reset");
    // The request follows the flag by one cycle, so its cause sits one cycle back
    chk_irq_cause: assert property ($rose(overflowIrq) |-> $past(overflowPulse) || $past(wr0))
        else $error("interrupt without cause");
    chk_flag_wipe: assert property ((wr3 || wr0 && regReq.wrData[5]) && !counterRunning
        && !$past(regReq.wrStrobe) |-> ##2 !overflowIrq)
        else $error("flag survived limit write or counter clear");
endmodule : interval_timer_chk

bind interval_timer interval_timer_chk #(.COUNT_W(COUNT_W)) u_interval_timer_chk (
    .clock(clock), .nrst(nrst), .regReq(regReq), .rdData(rdData),
    .extTimerClockIn(extTimerClockIn), .fixedClockTick(fixedClockTick),
    .overflowIrq(overflowIrq), .overflowPulse(overflowPulse), .counterRunning(counterRunning));

// ---- interval_timer_pkg.sv ----
// Shared constants and types for the 8-bit interval timer.
// Assumes a single bus clock; all users reference names as interval_timer_pkg::name.
package interval_timer_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 8;
    localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_CLOCK_CONFIG = 4'h1;
    localparam logic [3:0] OFS_COUNT_VALUE = 4'h2;
    localparam logic [3:0] OFS_WRAP_LIMIT = 4'h3;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SC_FLAG_BIT = 7;
    localparam int SC_IRQ_EN_BIT = 6;
    localparam int SC_CLEAR_BIT = 5;
    localparam int SC_HALT_BIT = 4;
    localparam int CLK_SRC_LSB = 4;
    localparam int CLK_SRC_W = 2;
    localparam int CLK_PRESCALE_LSB = 0;
    localparam int CLK_PRESCALE_W = 4;

    // ------------------------------------------------------------
    // Values after reset and limits
    // ------------------------------------------------------------
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_HALT = 1'b1;
    localparam logic [1:0] RST_CLOCK_SOURCE = 2'h0;
    localparam logic [3:0] RST_PRESCALE = 4'h0;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_WRAP_LIMIT = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [3:0] PRESCALE_MAX = 4'h8;
    // External clock may run at most at bus rate divided by this
    localparam int EXT_CLOCK_MIN_DIVIDE = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_BUS,
        SRC_FIXED,
        SRC_EXT_FALL,
        SRC_EXT_RISE
    } clock_source_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wrData;
        logic wrStrobe;
        logic rdStrobe;
    } reg_req_t;

endpackage : interval_timer_pkg

// ---- interval_timer_tb.sv ----
// Self-checking bench for the interval timer.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module interval_timer_tb;
    logic clock;
    logic nrst;
    interval_timer_pkg::reg_req_t regReq;
    logic [7:0] rdData;
    logic extTimerClockIn;
    logic fixedClockTick;
    logic overflowIrq;
    logic overflowPulse;
    logic counterRunning;
    int miscompares;
    int checks;
    int seed;
    int n;
    int lim;
    int pre;
    logic [7:0] d;
    logic [7:0] c0;

    interval_timer u_interval_timer (.clock(clock), .nrst(nrst), .regReq(regReq),
        .rdData(rdData), .extTimerClockIn(extTimerClockIn), .fixedClockTick(fixedClockTick),
        .overflowIrq(overflowIrq), .overflowPulse(overflowPulse),
        .counterRunning(counterRunning));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ----
    // Helpers
    // ----
    function automatic logic [7:0] exp_period(input int l, input int p);
        return 8'((l + 1) << p);
    endfunction : exp_period

    function automatic logic [7:0] exp_ticks(input int s, input int k);
        return 8'((s == 1) ? 2 * k : k);
    endfunction : exp_ticks

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        regReq.addr <= a;
        regReq.wrData <= v;
        regReq.wrStrobe <= 1'b1;
        @(posedge clock);
        regReq.wrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock);
        regReq.addr <= a;
        regReq.rdStrobe <= 1'b1;
        @(posedge clock);
        regReq.rdStrobe <= 1'b0;
        #1 v = rdData;
    endtask : rd

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        rd(a, d);
        cmp(d, e);
    endtask : rdc

    task automatic wait_pulse(output int k);
        k = 0;
        do begin
            @(posedge clock);
            #1 k++;
        end while (overflowPulse !== 1'b1 && k < 5000);
        if (k >= 5000) begin
            miscompares++;
            end_of_test();
        end
    endtask : wait_pulse

    // Runs until one wrap, then halts with the flag left set
    task automatic get_flag(input logic ien);
        wr(4'h0, {1'b0, ien, 6'h00});
        wait_pulse(n);
        wr(4'h0, {1'b0, ien, 6'h10});
    endtask : get_flag
    // ----
    // Main sequence
    // ----
    initial begin
        seed = 32'hb6acf395;
        miscompares = 0;
        checks = 0;
        nrst = 1'b0;
        regReq = '0;
        extTimerClockIn = 1'b0;
        fixedClockTick = 1'b0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        wr(4'hC, 8'hFF);
        rdc(4'h0, 8'h10);
        rdc(4'h1, 8'h00);
        rdc(4'h2, 8'h00);
        rdc(4'h3, 8'h00);
        rdc(4'hC, 8'h00);
        wr(4'h1, 8'hFF);
        rdc(4'h1, 8'h38);
        wr(4'h0, 8'hFF);
        rdc(4'h0, 8'h50);
        wr(4'h2, 8'h55);
        rdc(4'h2, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            lim = 1 + $unsigned($random(seed)) % 15;
            pre = $unsigned($random(seed)) % 3;
            wr(4'h1, pre[7:0]);
            wr(4'h3, lim[7:0]);
            wr(4'h0, 8'h20);
            wait_pulse(n);
            wait_pulse(n);
            cmp(n[7:0], exp_period(lim, pre));
        end
        $display("test wrap done");
        wr(4'h3, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h20);
        wr(4'h0, 8'h10);
        rd(4'h2, c0);
        rdc(4'h2, c0);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h10);
        rd(4'h2, d);
        cmp({7'h0, (d - c0) inside {[8'h01:8'h04]}}, 8'h01);
        $display("test halt done");
        wr(4'h3, 8'h02);
        get_flag(1'b0);
        #1 cmp({7'h0, overflowIrq}, 8'h00);
        wr(4'h0, 8'h10);
        rdc(4'h0, 8'h90);
        wr(4'h0, 8'h10);
        rdc(4'h0, 8'h10);
        get_flag(1'b0);
        wr(4'h0, 8'h30);
        rdc(4'h0, 8'h10);
        rdc(4'h2, 8'h00);
        get_flag(1'b0);
        wr(4'h3, 8'h02);
        rdc(4'h0, 8'h10);
        $display("test flag done");
        get_flag(1'b1);
        #1 cmp({7'h0, overflowIrq}, 8'h01);
        rd(4'h0, d);
        wr(4'h0, 8'h50);
        repeat (2) @(posedge clock);
        #1 cmp({7'h0, overflowIrq}, 8'h00);
        wr(4'h0, 8'h10);
        $display("test interrupt done");
        wr(4'h3, 8'h00);
        for (int s = 1; s < 4; s++) begin
            n = 3 + $unsigned($random(seed)) % 6;
            wr(4'h1, 8'(s << 4));
            wr(4'h0, 8'h20);
            // Pin period of 8 cycles keeps the edges within a quarter of the bus rate
            for (int j = 0; j < n; j++) begin
                repeat (4) @(posedge clock);
                extTimerClockIn <= 1'b1;
                fixedClockTick <= 1'b1;
                @(posedge clock);
                fixedClockTick <= 1'b0;
                @(posedge clock);
                fixedClockTick <= 1'b1;
                @(posedge clock);
                fixedClockTick <= 1'b0;
                @(posedge clock);
                extTimerClockIn <= 1'b0;
            end
            repeat (6) @(posedge clock);
            wr(4'h0, 8'h10);
            rdc(4'h2, exp_ticks(s, n));
        end
        $display("test sources done");
        end_of_test();
    end
endmodule : interval_timer_tb

// ---- tick_prescaler.sv ----
// Power-of-two prescaler: passes one of every 2^shift source ticks.
// Assumes srcTick is a one-cycle enable; output tick is combinational.
`timescale 1ns/10ps
module tick_prescaler #(
    parameter int DIV_W = 8
) (
    input wire logic clock,
    input wire logic rstN,
    input wire logic clear,
    input wire logic run,
    input wire logic srcTick,
    input wire logic [3:0] shift,
    output logic tick
);

    logic [DIV_W-1:0] divCount;
    logic [DIV_W-1:0] mask;

    initial begin
        if (DIV_W < 1 || DIV_W > 15) begin
            $error("tick_prescaler: DIV_W out of range");
        end
    end

    // ------------------------------------------------------------
    // Low shift bits all ones marks the last tick of a period
    // ------------------------------------------------------------
    always_comb begin
        mask = '0;
        for (int i = 0; i < DIV_W; i++) begin
            mask[i] = (i < int'(shift));
        end
    end

    assign tick = run & srcTick & ((divCount & mask) == mask);

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            divCount <= '0;
        end else if (clear) begin
            divCount <= '0;
        end else if (run && srcTick) begin
            divCount <= divCount + 1'b1;
        end
    end

endmodule : tick_prescaler
